// File: flyback_startup_fault_sequencer_bench.sv
// testbench: self-checking run of the flyback start-up sequencer
`timescale 1ns/1ps
module flyback_startup_fault_sequencer_bench import fssq_pkg::*; ();
	localparam int GATE = 6;
	localparam int DEMD = 4;
	localparam int HVON = 3;
	localparam int LOWP = 0;
	localparam int unsigned T_LONG = 400;
	localparam int unsigned T_SHORT = 50;
	localparam int unsigned T_UV = 40;
	localparam int unsigned T_WIN = 20;
	localparam int unsigned T_SMP = 300;
	localparam int unsigned T_BURST = 100;
	logic [3:0] sel = 4'hf;
	logic [LINE_W-1:0] off_thr = 10'h100;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] o_dat;
	logic o_ack;
	logic o_irq;
	fssq_drive_s drive;
	fssq_sense_s sense;
	logic collapse = 1'b0;
	logic [3:0] flags = 4'h6;
	logic [LINE_W-1:0] line_code = 10'h200;
	logic [LINE_W-1:0] bulk = 10'h0;
	logic valid = 1'b0;
	logic [31:0] r;
	logic [63:0] pair;
	logic [63:0] exp_q[$];
	int seed = 42;
	int num_errors = 0;
	int check_count = 0;
	always #20 i_clk = ~i_clk;
	fssq_sequencer #(.RESET_LONG_N(T_LONG), .RESET_SHORT_N(T_SHORT), .UV_DELAY_N(T_UV),
		.WIN_N(T_WIN), .SMP_INT_N(T_SMP), .BURST_WAIT_N(T_BURST)) dut_u (.i_clk(i_clk),
		.i_arst_n(i_arst_n), .i_sense(sense), .i_bulk_sample(bulk), .i_bulk_valid(valid),
		.i_line_turn_off_threshold(off_thr), .i_cyc(cyc), .i_stb(stb), .i_we(we), .i_adr(adr),
		.i_sel(sel), .i_dat(dat), .o_dat(o_dat), .o_ack(o_ack), .o_drive(drive), .o_irq(o_irq));
	fssq_front_end fe_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_drive(drive),
		.i_collapse(collapse), .i_flags(flags), .o_sense(sense));
	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// reads carry the expected value in d and a compare mask in m
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] m);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= w ? d : 32'h0;
		if (!w) exp_q.push_back({m, d & m});
		do begin
			@(posedge i_clk);
			n++;
		end while (o_ack !== 1'b1 && n < 50);
		if (o_ack !== 1'b1) check({31'h0, o_ack}, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_bit(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (drive[b] !== v && n < lim) begin
			@(posedge i_clk);
			n++;
		end
		check({31'h0, drive[b]}, {31'h0, v});
	endtask
	// ----
	// read monitor, noisy bulk samples, watchdog
	// ----
	always @(posedge i_clk) begin
		if (o_ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			pair = exp_q.pop_front();
			check(o_dat & pair[63:32], pair[31:0]);
		end
	end
	always @(posedge i_clk) begin
		r = $random(seed);
		valid <= r[0];
		bulk <= line_code + {7'h0, r[3:1]};
	end
	initial begin
		repeat (80000) @(posedge i_clk);
		num_errors++;
		report_and_stop();
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'b1;
		// byte 0 deselected: the enable bit must survive a zero write
		sel <= 4'he;
		bus(1'b1, REG_CTRL, 32'h0, 32'h0);
		sel <= 4'hf;
		bus(1'b0, REG_CTRL, CTRL_RESET, 32'hffffffff);
		bus(1'b0, REG_STATE, 32'h0, 32'h7);
		bus(1'b0, 4'h6, 32'h0, 32'hffffffff);
		bus(1'b1, REG_IRQ_MASK, 32'h1f, 32'h0);
		wait_bit(GATE, 1'b1, 3000);
		bus(1'b1, REG_IRQ_STAT, 32'h1f, 32'h0);
		check({31'h0, o_irq}, 32'h0);
		bus(1'b0, REG_STATE, 32'h2, 32'h3);
		line_code <= 10'h080;
		flags <= 4'h2;
		wait_bit(LOWP, 1'b1, 300);
		check({31'h0, o_irq}, 32'h1);
		bus(1'b0, REG_IRQ_STAT, 32'h4, 32'h4);
		wait_bit(DEMD, 1'b1, 500);
		wait_bit(LOWP, 1'b1, 2500);
		bus(1'b0, REG_IRQ_STAT, 32'h2, 32'h2);
		bus(1'b1, REG_IRQ_MASK, 32'h0, 32'h0);
		check({31'h0, o_irq}, 32'h0);
		bus(1'b1, REG_IRQ_STAT, 32'h1f, 32'h0);
		bus(1'b1, REG_IRQ_MASK, 32'h1f, 32'h0);
		wait_bit(DEMD, 1'b1, 500);
		line_code <= 10'h200;
		flags <= 4'h6;
		wait_bit(GATE, 1'b1, 2500);
		collapse <= 1'b1;
		wait_bit(LOWP, 1'b1, 100);
		wait_bit(HVON, 1'b1, 60);
		collapse <= 1'b0;
		bus(1'b0, REG_IRQ_STAT, 32'h1, 32'h1);
		wait_bit(GATE, 1'b1, 2500);
		flags <= 4'h5;
		wait_bit(LOWP, 1'b1, 400);
		bus(1'b0, REG_IRQ_STAT, 32'h10, 32'h10);
		wait_bit(HVON, 1'b1, 200);
		wait_bit(GATE, 1'b1, 2500);
		wait_bit(LOWP, 1'b1, 400);
		wait_bit(HVON, 1'b1, 200);
		flags <= 4'h7;
		wait_bit(GATE, 1'b1, 2500);
		repeat (7000) @(posedge i_clk);
		flags <= 4'h6;
		collapse <= 1'b1;
		wait_bit(LOWP, 1'b1, 100);
		wait_bit(HVON, 1'b1, 60);
		collapse <= 1'b0;
		wait_bit(DEMD, 1'b1, 500);
		repeat (100) @(posedge i_clk);
		flags <= 4'he;
		wait_bit(LOWP, 1'b1, 3);
		check({31'h0, drive.min_demand}, 32'h0);
		flags <= 4'h6;
		bus(1'b0, REG_IRQ_STAT, 32'h8, 32'h8);
		wait_bit(HVON, 1'b1, 400);
		bus(1'b0, REG_STATE, 32'h1, 32'h3);
		bus(1'b1, REG_CTRL, 32'h3, 32'h0);
		wait_bit(GATE, 1'b1, 3000);
		report_and_stop();
	end
endmodule

// File: fssq_front_end.sv
// partner: behavioural analog front end with a bias rail model
`timescale 1ns/1ps
module fssq_front_end import fssq_pkg::*; (
	input wire logic i_clk, // clock
	input wire logic i_arst_n, // async reset, active low
	input wire fssq_drive_s i_drive, // controls from the sequencer
	input wire logic i_collapse, // bias winding fault
	input wire logic [3:0] i_flags, // ovp, line on, ripple ok, light load
	output fssq_sense_s o_sense // comparator levels
);
	int bias_q;
	// ----
	// rail: source charges it, limited current is slower, drain is fast
	// ----
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bias_q <= 0;
		end else if (i_drive.bias_discharge) begin
			bias_q <= (bias_q > 4) ? bias_q - 4 : 0;
		end else if (i_collapse) begin
			bias_q <= (bias_q > 2) ? bias_q - 2 : 0;
		end else if (i_drive.hv_source_on && bias_q < 100) begin
			bias_q <= bias_q + (i_drive.hv_source_limited ? 1 : 2);
		end
	end
	always_comb begin
		o_sense.bias_stop_threshold = bias_q < 20;
		o_sense.bias_reset_level = bias_q <= 10;
		o_sense.bias_start_level = bias_q >= 80;
		o_sense.bias_short_release_level = bias_q > 30;
		o_sense.output_overvoltage = i_flags[3];
		o_sense.line_turn_on_threshold = i_flags[2];
		o_sense.ac_ripple_ok = i_flags[1];
		o_sense.light_load = i_flags[0];
	end
endmodule

// File: fssq_pkg.sv
// package: constants, states and carriers for the flyback start-up sequencer
package fssq_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned WIN_MS = 11;
	localparam int unsigned WIN_CYC = CLK_HZ / 1000 * WIN_MS;
	localparam int unsigned RESET_LONG_US = 1000000;
	localparam int unsigned RESET_SHORT_US = 1000000;
	localparam int unsigned UV_DELAY_US = 40000;
	localparam int unsigned PROBE_HZ = 40000;
	localparam int unsigned PROBE_CYC = CLK_HZ / PROBE_HZ;
	localparam int unsigned PROBE_ON_CYC = 8;
	localparam logic [1:0] PROBE_COUNT = 2'h3;
	localparam int unsigned SMP_ON_US = 10;
	localparam int unsigned SMP_INT_US = 1000;
	localparam int unsigned BURST_WAIT_US = 3000000;
	localparam logic [4:0] BURST_LEN = 5'h15;
	localparam int unsigned RESET_LONG_CYC = CLK_HZ / 1000000 * RESET_LONG_US;
	localparam int unsigned RESET_SHORT_CYC = CLK_HZ / 1000000 * RESET_SHORT_US;
	localparam int unsigned UV_DELAY_CYC = CLK_HZ / 1000000 * UV_DELAY_US;
	localparam int unsigned SMP_ON_CYC = CLK_HZ / 1000000 * SMP_ON_US;
	localparam int unsigned SMP_INT_CYC = CLK_HZ / 1000000 * SMP_INT_US;
	localparam int unsigned BURST_WAIT_CYC = CLK_HZ / 1000000 * BURST_WAIT_US;
	localparam int unsigned LINE_W = 10;
	// register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATE = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK = 4'hc;
	localparam logic [3:0] REG_PEAK = 4'h0;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_CLEAR_LATCH_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_STOP = 0;
	localparam int unsigned IRQ_LINE_LOW = 1;
	localparam int unsigned IRQ_BROWNOUT = 2;
	localparam int unsigned IRQ_OVP = 3;
	localparam int unsigned IRQ_DC = 4;

	typedef enum logic [2:0] {
		FSSQ_CHARGE = 3'b000,
		FSSQ_PROBE = 3'b001,
		FSSQ_RUN = 3'b010,
		FSSQ_WAIT = 3'b011,
		FSSQ_DRAIN = 3'b100,
		FSSQ_LATCH = 3'b101
	} fssq_state_e;

	typedef struct packed {
		logic bias_stop_threshold;
		logic bias_reset_level;
		logic bias_start_level;
		logic bias_short_release_level;
		logic output_overvoltage;
		logic line_turn_on_threshold;
		logic ac_ripple_ok;
		logic light_load;
	} fssq_sense_s;

	typedef struct packed {
		logic gate_enable;
		logic probe_pulse;
		logic min_demand;
		logic hv_source_on;
		logic hv_source_limited;
		logic bias_discharge;
		logic low_power;
	} fssq_drive_s;
endpackage

// File: fssq_sequencer.sv
// flyback start-up, brownout and ac-disconnect supervisory sequencer
`timescale 1ns/1ps
// Overview of operation
// RQ1: bias below stop level: stop gate, low power until long delay or reset level.
// RQ2: after that delay, drain bias to reset level, turn source on, restart.
// RQ3: at bias start level turn high-voltage source off, then test bulk voltage.
// RQ4: emit three probe pulses at probe frequency with minimum peak demand.
// RQ5: overvoltage during probing aborts remaining pulses and latches the fault.
// RQ6: no overvoltage: finish pulses; line above turn-on threshold starts regulation.
// RQ7: line below turn-on: short delay, drain bias, repeat start-up forever.
// RQ8: while running, hold maximum sensed bulk over each 11 ms window as peak.
// RQ9: peak under turn-off for persistence delay: halt, short delay, drain, restart.
// RQ10: insufficient ripple flags dc, then short delay, drain, source back on.
// RQ11: any steady dc on the high-voltage pin gives repeating start/stop cycling.
// RQ12: sample source on-time at sample interval, bursts of 21, then burst wait.
// RQ13: burst schedule keeps average source duty near 0.2 percent; the constants give about 0.007 percent.
// RQ14: monitor enabled only in latched fault or below light-load fraction.
// RQ15: monitor disabled when delivered power is above light-load fraction.
// RQ16: limit source current until bias reaches short release level, then full.
// RQ17: explicit encoded states; move only on qualified conditions.
// RQ18: all delays timed by counters with parameterised terminal counts.
module fssq_sequencer import fssq_pkg::*; #(
	parameter int unsigned RESET_LONG_N = RESET_LONG_CYC,
	parameter int unsigned RESET_SHORT_N = RESET_SHORT_CYC,
	parameter int unsigned UV_DELAY_N = UV_DELAY_CYC,
	parameter int unsigned WIN_N = WIN_CYC,
	parameter int unsigned SMP_INT_N = SMP_INT_CYC,
	parameter int unsigned BURST_WAIT_N = BURST_WAIT_CYC
) (
	input wire logic i_clk, // 25 mhz clock
	input wire logic i_arst_n, // async reset, active low
	input wire fssq_sense_s i_sense, // comparator results from front end
	input wire logic [LINE_W-1:0] i_bulk_sample, // sensed bulk voltage code
	input wire logic i_bulk_valid, // bulk sample strobe
	input wire logic [LINE_W-1:0] i_line_turn_off_threshold, // brownout level code
	input wire logic i_cyc, // wishbone cycle
	input wire logic i_stb, // wishbone strobe
	input wire logic i_we, // wishbone write enable
	input wire logic [3:0] i_adr, // wishbone byte address
	input wire logic [3:0] i_sel, // wishbone byte selects
	input wire logic [31:0] i_dat, // wishbone write data
	output logic [31:0] o_dat, // wishbone read data
	output logic o_ack, // wishbone acknowledge
	output fssq_drive_s o_drive, // drive and mode controls
	output logic o_irq // level interrupt
);
	// -------------------------------------------------------------
	// state and counters
	// -------------------------------------------------------------
	fssq_state_e state_q;
	logic [31:0] tmr_q;
	logic [31:0] per_q;
	logic [1:0] pulses_q;
	logic uv_flag_q;
	logic [31:0] uv_cnt_q;
	logic [31:0] win_cnt_q;
	logic [LINE_W-1:0] win_max_q;
	logic [LINE_W-1:0] peak_q;
	logic peak_ok_q;
	logic [31:0] smp_cnt_q;
	logic [4:0] smp_num_q;
	logic smp_wait_q;
	logic smp_on;
	logic mon_en;
	logic dc_event;
	logic [31:0] ctrl_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] ev;
	logic wb_req;
	logic wb_wr;
	logic from_stop_q;
	logic run_enable;

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign run_enable = ctrl_q[CTRL_ENABLE_BIT];
	assign wb_req = i_cyc && i_stb && !o_ack;
	assign wb_wr = wb_req && i_we;

	// -------------------------------------------------------------
	// ac-disconnect monitor gating and burst sampling
	// -------------------------------------------------------------
	// monitor only matters when the load cannot drain the x-capacitor itself
	assign mon_en = (state_q == FSSQ_LATCH) // RQ14
		|| (state_q == FSSQ_RUN && i_sense.light_load); // RQ15
	// on-time is a short slice at the head of each interval; burst wait keeps duty low
	assign smp_on = mon_en && !smp_wait_q && (smp_cnt_q < SMP_ON_CYC); // RQ12 RQ13
	// ripple judged at the end of each sample on-time
	assign dc_event = mon_en && !smp_wait_q && (smp_cnt_q == SMP_ON_CYC - 1)
		&& !i_sense.ac_ripple_ok; // RQ10 RQ11

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			smp_cnt_q <= 32'h0;
			smp_num_q <= 5'h0;
			smp_wait_q <= 1'b0;
		end else if (!mon_en) begin
			smp_cnt_q <= 32'h0;
			smp_num_q <= 5'h0;
			smp_wait_q <= 1'b0;
		end else if (smp_wait_q) begin
			if (smp_cnt_q >= BURST_WAIT_N - 1) begin // RQ12 RQ18
				smp_cnt_q <= 32'h0;
				smp_wait_q <= 1'b0;
			end else begin
				smp_cnt_q <= smp_cnt_q + 32'h1;
			end
		end else if (smp_cnt_q >= SMP_INT_N - 1) begin
			smp_cnt_q <= 32'h0;
			if (smp_num_q == BURST_LEN - 5'h1) begin // RQ12
				smp_num_q <= 5'h0;
				smp_wait_q <= 1'b1;
			end else begin
				smp_num_q <= smp_num_q + 5'h1;
			end
		end else begin
			smp_cnt_q <= smp_cnt_q + 32'h1;
		end
	end

	// -------------------------------------------------------------
	// ac peak capture and brownout persistence
	// -------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			win_cnt_q <= 32'h0;
			win_max_q <= '0;
			peak_q <= '0;
			peak_ok_q <= 1'b0;
		end else if (state_q != FSSQ_RUN) begin
			win_cnt_q <= 32'h0;
			win_max_q <= '0;
			// a stale peak from an earlier run must not count toward brownout
			peak_ok_q <= 1'b0;
		end else if (win_cnt_q >= WIN_N - 1) begin // RQ8
			win_cnt_q <= 32'h0;
			peak_ok_q <= 1'b1;
			peak_q <= (i_bulk_valid && i_bulk_sample > win_max_q) ? i_bulk_sample : win_max_q;
			win_max_q <= '0;
		end else begin
			win_cnt_q <= win_cnt_q + 32'h1;
			if (i_bulk_valid && i_bulk_sample > win_max_q) begin // RQ8
				win_max_q <= i_bulk_sample;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			uv_cnt_q <= 32'h0;
			uv_flag_q <= 1'b0;
		end else if (state_q != FSSQ_RUN || !peak_ok_q
			|| peak_q >= i_line_turn_off_threshold) begin
			uv_cnt_q <= 32'h0;
			uv_flag_q <= 1'b0;
		end else if (uv_cnt_q >= UV_DELAY_N - 1) begin // RQ9 RQ18
			uv_flag_q <= 1'b1;
		end else begin
			uv_cnt_q <= uv_cnt_q + 32'h1;
		end
	end

	// -------------------------------------------------------------
	// main sequencer
	// -------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= FSSQ_CHARGE;
			tmr_q <= 32'h0;
			per_q <= 32'h0;
			pulses_q <= 2'h0;
			from_stop_q <= 1'b0;
		end else begin
			case (state_q) // RQ17
			FSSQ_CHARGE: begin
				if (i_sense.bias_start_level && run_enable) begin // RQ3
					state_q <= FSSQ_PROBE;
					per_q <= 32'h0;
					pulses_q <= 2'h0;
				end
			end
			FSSQ_PROBE: begin
				if (i_sense.output_overvoltage) begin // RQ5
					state_q <= FSSQ_LATCH;
				end else if (i_sense.bias_stop_threshold) begin // RQ1
					state_q <= FSSQ_WAIT;
					tmr_q <= 32'h0;
					from_stop_q <= 1'b1;
				end else if (per_q >= PROBE_CYC - 1) begin // RQ4
					per_q <= 32'h0;
					if (pulses_q == PROBE_COUNT - 2'h1) begin
						if (i_sense.line_turn_on_threshold) begin // RQ6
							state_q <= FSSQ_RUN;
						end else begin // RQ7
							state_q <= FSSQ_WAIT;
							tmr_q <= 32'h0;
							from_stop_q <= 1'b0;
						end
					end else begin
						pulses_q <= pulses_q + 2'h1;
					end
				end else begin
					per_q <= per_q + 32'h1;
				end
			end
			FSSQ_RUN: begin
				if (i_sense.output_overvoltage) begin
					state_q <= FSSQ_LATCH;
				end else if (i_sense.bias_stop_threshold) begin // RQ1
					state_q <= FSSQ_WAIT;
					tmr_q <= 32'h0;
					from_stop_q <= 1'b1;
				end else if (uv_flag_q || dc_event) begin // RQ9 RQ10
					state_q <= FSSQ_WAIT;
					tmr_q <= 32'h0;
					from_stop_q <= 1'b0;
				end
			end
			FSSQ_WAIT: begin
				// long wait after a bias collapse ends early at the reset level
				if (from_stop_q && i_sense.bias_reset_level) begin // RQ1
					state_q <= FSSQ_CHARGE;
				end else if (tmr_q >= (from_stop_q ? RESET_LONG_N : RESET_SHORT_N) - 1) begin // RQ18
					state_q <= FSSQ_DRAIN; // RQ2 RQ7
				end else begin
					tmr_q <= tmr_q + 32'h1;
				end
			end
			FSSQ_DRAIN: begin
				if (i_sense.bias_reset_level) begin // RQ2
					state_q <= FSSQ_CHARGE;
				end
			end
			FSSQ_LATCH: begin
				// cleared by ac disconnect or software; both restart through a drain
				if (dc_event || ctrl_q[CTRL_CLEAR_LATCH_BIT]) begin // RQ10 RQ11
					state_q <= FSSQ_WAIT;
					tmr_q <= 32'h0;
					from_stop_q <= 1'b0;
				end
			end
			default: begin
				state_q <= FSSQ_CHARGE;
			end
			endcase
		end
	end

	// -------------------------------------------------------------
	// drive outputs
	// -------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_drive <= '0;
		end else begin
			o_drive.gate_enable <= (state_q == FSSQ_RUN);
			o_drive.probe_pulse <= (state_q == FSSQ_PROBE) && (per_q < PROBE_ON_CYC); // RQ4
			o_drive.min_demand <= (state_q == FSSQ_PROBE); // RQ4
			o_drive.hv_source_on <= (state_q == FSSQ_CHARGE && !i_sense.bias_start_level) // RQ3
				|| smp_on; // RQ12
			o_drive.hv_source_limited <= !i_sense.bias_short_release_level; // RQ16
			o_drive.bias_discharge <= (state_q == FSSQ_DRAIN); // RQ2
			o_drive.low_power <= (state_q == FSSQ_WAIT) || (state_q == FSSQ_LATCH); // RQ1
		end
	end

	// -------------------------------------------------------------
	// registers and interrupts
	// -------------------------------------------------------------
	assign ev[IRQ_STOP] = state_q != FSSQ_WAIT && i_sense.bias_stop_threshold
		&& (state_q == FSSQ_RUN || state_q == FSSQ_PROBE);
	assign ev[IRQ_LINE_LOW] = state_q == FSSQ_PROBE && per_q >= PROBE_CYC - 1
		&& pulses_q == PROBE_COUNT - 2'h1 && !i_sense.line_turn_on_threshold;
	assign ev[IRQ_BROWNOUT] = state_q == FSSQ_RUN && uv_flag_q;
	assign ev[IRQ_OVP] = state_q != FSSQ_LATCH && i_sense.output_overvoltage
		&& (state_q == FSSQ_RUN || state_q == FSSQ_PROBE);
	assign ev[IRQ_DC] = dc_event;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (wb_wr && i_adr == REG_CTRL) begin
			ctrl_q <= byte_merge(ctrl_q, i_dat, i_sel) & 32'h00000003;
		end else begin
			ctrl_q[CTRL_CLEAR_LATCH_BIT] <= 1'b0; // self-clearing
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask_q <= '0;
		end else if (wb_wr && i_adr == REG_IRQ_MASK && i_sel[0]) begin
			irq_mask_q <= i_dat[IRQ_W-1:0];
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_q <= '0;
		end else if (wb_wr && i_adr == REG_IRQ_STAT && i_sel[0]) begin
			irq_stat_q <= (irq_stat_q & ~i_dat[IRQ_W-1:0]) | ev;
		end else begin
			irq_stat_q <= irq_stat_q | ev;
		end
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack <= 1'b0;
			o_dat <= 32'h0;
		end else begin
			o_ack <= wb_req;
			if (wb_req && !i_we) begin
				case (i_adr)
				REG_CTRL: o_dat <= ctrl_q;
				REG_STATE: o_dat <= {16'h0, peak_q, smp_wait_q, 1'b0, pulses_q, 2'h0}
					| {29'h0, state_q};
				REG_IRQ_STAT: o_dat <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
				REG_IRQ_MASK: o_dat <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
				default: o_dat <= 32'h0;
				endcase
			end
		end
	end
endmodule

// File: fssq_sequencer_asserts.sv
// checker: port-level properties of the flyback start-up sequencer
`timescale 1ns/1ps
module fssq_sequencer_asserts import fssq_pkg::*; (
	input wire logic i_clk, // clock
	input wire logic i_arst_n, // async reset, active low
	input wire fssq_sense_s i_sense, // front end levels
	input wire logic i_cyc, // bus cycle
	input wire logic i_stb, // bus strobe
	input wire logic o_ack, // bus acknowledge
	input wire fssq_drive_s o_drive // drive controls
);
	logic [1:0] pulse_cnt_q;
	logic [15:0] hv_len_q;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// ----
	// helper counters
	// ----
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pulse_cnt_q <= 2'h0;
		end else if (!o_drive.min_demand) begin
			pulse_cnt_q <= 2'h0;
		end else if ($rose(o_drive.probe_pulse)) begin
			pulse_cnt_q <= pulse_cnt_q + 2'h1;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hv_len_q <= 16'h0;
		end else begin
			hv_len_q <= o_drive.hv_source_on ? hv_len_q + 16'h1 : 16'h0;
		end
	end
	// ----
	// properties
	// ----
	ack_answer_a: assert property (i_cyc && i_stb && !o_ack |=> o_ack)
		else $error("bus request not answered next cycle");
	ack_pulse_a: assert property (o_ack |=> !o_ack)
		else $error("acknowledge longer than one cycle");
	stop_halt_a: assert property (o_drive.gate_enable && i_sense.bias_stop_threshold |->
		##[1:2] (!o_drive.gate_enable && o_drive.low_power))
		else $error("bias stop did not halt switching");
	drain_exit_a: assert property (o_drive.bias_discharge && i_sense.bias_reset_level |->
		##[1:2] !o_drive.bias_discharge)
		else $error("drain kept past reset level");
	probe_source_a: assert property (o_drive.min_demand |-> !o_drive.hv_source_on)
		else $error("source on while probing");
	pulse_width_a: assert property ($rose(o_drive.probe_pulse) |->
		o_drive.probe_pulse [*8] ##1 !o_drive.probe_pulse)
		else $error("probe pulse width wrong");
	probe_count_a: assert property ($rose(o_drive.gate_enable) |-> pulse_cnt_q == 2'h3)
		else $error("regulation began without three probe pulses");
	ovp_abort_a: assert property (o_drive.min_demand && i_sense.output_overvoltage |->
		##[1:2] (o_drive.low_power && !o_drive.min_demand))
		else $error("overvoltage did not abort probing");
	monitor_off_a: assert property ((o_drive.gate_enable && !i_sense.light_load) [*3] |->
		!o_drive.hv_source_on)
		else $error("monitor sampling above light load");
	// a sample cut short by the load leaving light-load range is legal
	sample_on_a: assert property ($fell(o_drive.hv_source_on) && o_drive.gate_enable
		&& $past(i_sense.light_load) |-> hv_len_q == 16'h00fa)
		else $error("sample on-time wrong");
	limit_src_a: assert property (i_sense.bias_short_release_level [*2] |->
		!o_drive.hv_source_limited)
		else $error("source still limited past release level");
	state_excl_a: assert property (o_drive.gate_enable |->
		!(o_drive.min_demand || o_drive.bias_discharge || o_drive.low_power))
		else $error("regulating while in another mode");
	cover property ($rose(o_drive.gate_enable));
	cover property (o_drive.min_demand && i_sense.output_overvoltage);
	cover property ($fell(o_drive.hv_source_on) && o_drive.gate_enable);
endmodule
bind fssq_sequencer fssq_sequencer_asserts chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
	.i_sense(i_sense), .i_cyc(i_cyc), .i_stb(i_stb), .o_ack(o_ack), .o_drive(o_drive));
